// ---- rtl/iap_port.v ----
// host-side result and register port of a three-channel image digitizer
// Operation
// R1: a high port select takes register writes from the shared bus, a low one from the serial pins.
// R2: the clamp input turns the input clamp bias on when high and off when low.
// R3: bus pins 0 to 9 carry result bits 0 to 9 and also register data bits 0 to 9.
// R4: bus pins 10 to 12 carry result bits 10 to 12 and also the 3-bit register address.
// R5: in demultiplexed mode result bits 0 to 5 appear on the six pins from bus bit eight up.
// R6: output enable low while port select is high is the inhibit mode, a distinct state.
// R7: in single-channel mode channel select low set and high clear picks the blue channel.
// R8: result words on the bus are updated in step with the conversion clock edges.
// R9: the result drivers release the bus while output enable is high and drive it while low.
// R10: configuration bit 7 chooses normal output when clear and demultiplexed output when set.
// R11: in demultiplexed mode the upper 8 bits go out at the rising and the lower 6 at the falling edge.
// R12: the controller holds address and data steady through the write strobe with results disabled.
`timescale 1ns/1ps
`include "iap_defs.vh"

module iap_port #(
    parameter BUS_W = `IAP_BUS_W,
    parameter DATA_W = `IAP_REG_DATA_W,
    parameter ADDR_W = `IAP_REG_ADDR_W,
    parameter REG_COUNT = `IAP_REG_COUNT
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_conversion_clock,
    input wire i_port_select,
    input wire i_clamp_enable,
    input wire i_out_enable_n,
    input wire i_register_write_strobe,
    input wire i_register_read_strobe,
    input wire i_serial_config_data,
    input wire i_serial_shift_clock,
    input wire [BUS_W-1:0] i_bus_in,
    output reg [BUS_W-1:0] o_bus_out,
    output reg [BUS_W-1:0] o_bus_oe_n,
    input wire [BUS_W-1:0] i_result_data,
    input wire i_result_valid,
    output wire o_result_ready,
    output reg o_clamp_bias,
    output reg o_inhibit,
    output reg o_output_demux,
    output reg o_single_channel,
    output reg [1:0] o_active_channel,
    output reg o_mux_reverse,
    output reg o_config_written
);

    reg [DATA_W-1:0] cfg_mem [0:REG_COUNT-1];
    reg prev_conv;
    reg prev_sclk;
    reg prev_wrt;
    reg [`IAP_SER_W-1:0] ser_shift;
    reg [3:0] ser_count;
    reg [BUS_W-1:0] cur_word;
    reg demux_phase;
    reg [BUS_W-1:0] next_bus_out;
    reg [BUS_W-1:0] next_bus_oe_n;
    reg [1:0] next_channel;
    wire conv_rise;
    wire conv_fall;
    wire sclk_rise;
    wire wrt_rise;
    wire wrt_fall;
    wire [ADDR_W-1:0] bus_addr;
    wire [DATA_W-1:0] cfg_word;
    wire [DATA_W-1:0] read_word;
    wire read_active;
    wire result_drive;
    wire inhibit_now;
    wire par_write;
    wire ser_write;
    wire [ADDR_W-1:0] ser_addr;
    wire [DATA_W-1:0] ser_data;
    wire [BUS_W-1:0] buf_data;
    wire buf_valid;
    integer i;

    // pins are sampled in the system clock domain, so edges are found by comparison
    assign conv_rise = i_conversion_clock && !prev_conv; // [R8]
    assign conv_fall = !i_conversion_clock && prev_conv; // [R8]
    assign sclk_rise = i_serial_shift_clock && !prev_sclk;
    assign wrt_rise = i_register_write_strobe && !prev_wrt;
    assign wrt_fall = !i_register_write_strobe && prev_wrt;

    assign bus_addr = i_bus_in[`IAP_REG_ADDR_MSB:`IAP_REG_ADDR_LSB]; // [R4]
    assign cfg_word = cfg_mem[`IAP_CFG_ADDR];
    assign read_word = cfg_mem[bus_addr];

    // bus shared with register traffic: results go out only when the parallel port is idle
    assign inhibit_now = !i_out_enable_n && i_port_select; // [R6]
    assign result_drive = !i_out_enable_n && !i_port_select; // [R9]
    assign read_active = i_port_select && i_register_read_strobe && i_out_enable_n;

    // the controller keeps address and data steady around the strobe edge, so one sample is enough
    assign par_write = i_port_select && wrt_rise; // [R1] [R12]
    assign ser_write = !i_port_select && wrt_fall && (ser_count == `IAP_SER_FRAME_BITS); // [R1]
    assign ser_addr = ser_shift[`IAP_SER_W-1:DATA_W];
    assign ser_data = ser_shift[DATA_W-1:0];

    iap_skid_buf #(
        .WIDTH(BUS_W),
        .DEPTH(2),
        .AW(1)
    ) u_buf (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_in_data(i_result_data),
        .i_in_valid(i_result_valid),
        .o_in_ready(o_result_ready),
        .o_out_data(buf_data),
        .o_out_valid(buf_valid),
        .i_out_ready(conv_rise)
    );

    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            prev_conv <= 1'b0;
            prev_sclk <= 1'b0;
            prev_wrt <= 1'b0;
        end
        else
        begin
            prev_conv <= i_conversion_clock;
            prev_sclk <= i_serial_shift_clock;
            prev_wrt <= i_register_write_strobe;
        end
    end

    // serial frame: address first, then data, most significant bit first, while the strobe is high
    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            ser_shift <= {`IAP_SER_W{1'b0}};
            ser_count <= 4'h0;
        end
        else if (i_port_select || !i_register_write_strobe)
        begin
            ser_count <= 4'h0;
        end
        else if (sclk_rise)
        begin
            ser_shift <= {ser_shift[`IAP_SER_W-2:0], i_serial_config_data}; // [R1]
            // a frame that runs long is dropped rather than committed misaligned
            if (ser_count != `IAP_SER_COUNT_MAX)
            begin
                ser_count <= ser_count + 4'h1;
            end
        end
    end

    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            for (i = 0; i < REG_COUNT; i = i + 1)
            begin
                cfg_mem[i] <= `IAP_REG_RESET;
            end
            o_config_written <= 1'b0;
        end
        else
        begin
            o_config_written <= par_write || ser_write;
            if (par_write)
            begin
                cfg_mem[bus_addr] <= i_bus_in[`IAP_REG_DATA_MSB:0]; // [R3] [R4]
            end
            else if (ser_write)
            begin
                cfg_mem[ser_addr] <= ser_data; // [R1]
            end
        end
    end

    // word and part selection follow the conversion clock; an empty buffer repeats the last word
    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            cur_word <= {BUS_W{1'b0}};
            demux_phase <= `IAP_PHASE_HIGH;
        end
        else if (conv_rise)
        begin
            if (buf_valid)
            begin
                cur_word <= buf_data; // [R8]
            end
            demux_phase <= `IAP_PHASE_HIGH; // [R11]
        end
        else if (conv_fall)
        begin
            demux_phase <= `IAP_PHASE_LOW; // [R11]
        end
    end

    always @*
    begin
        next_bus_out = {BUS_W{1'b0}};
        next_bus_oe_n = {BUS_W{1'b1}};
        if (read_active)
        begin
            next_bus_out[`IAP_REG_DATA_MSB:0] = read_word; // [R3]
            next_bus_oe_n[`IAP_REG_DATA_MSB:0] = {DATA_W{1'b0}};
        end
        else if (result_drive)
        begin
            // the registered format bit makes pin enables follow the mode output one cycle later
            if (!o_output_demux)
            begin
                next_bus_out = cur_word; // [R10] [R3] [R4]
                next_bus_oe_n = {BUS_W{1'b0}}; // [R9]
            end
            else if (demux_phase == `IAP_PHASE_HIGH)
            begin
                next_bus_out[BUS_W-1:`IAP_HIGH_PART_LSB] =
                    cur_word[BUS_W-1:`IAP_HIGH_PART_LSB]; // [R11]
                next_bus_oe_n[BUS_W-1:`IAP_HIGH_PART_LSB] =
                    {(BUS_W-`IAP_HIGH_PART_LSB){1'b0}}; // [R9]
            end
            else
            begin
                next_bus_out[BUS_W-1:`IAP_LOW_PART_PIN_LSB] =
                    cur_word[`IAP_LOW_PART_MSB:0]; // [R5] [R11]
                next_bus_oe_n[BUS_W-1:`IAP_LOW_PART_PIN_LSB] =
                    {(BUS_W-`IAP_LOW_PART_PIN_LSB){1'b0}}; // [R9]
            end
        end
    end

    // channel decode; only the blue code is pinned down, the other codes are a fixed choice
    always @*
    begin
        case ({cfg_word[`IAP_CFG_CHSEL_HIGH_BIT], cfg_word[`IAP_CFG_CHSEL_LOW_BIT]})
            2'h1:
            begin
                next_channel = `IAP_CHAN_BLUE; // [R7]
            end
            2'h2:
            begin
                next_channel = `IAP_CHAN_GREEN;
            end
            default:
            begin
                next_channel = `IAP_CHAN_RED;
            end
        endcase
    end

    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            o_bus_out <= {BUS_W{1'b0}};
            o_bus_oe_n <= {BUS_W{1'b1}};
            o_clamp_bias <= 1'b0;
            o_inhibit <= 1'b0;
            o_output_demux <= 1'b0;
            o_single_channel <= 1'b0;
            o_active_channel <= `IAP_CHAN_RED;
            o_mux_reverse <= 1'b0;
        end
        else
        begin
            o_bus_out <= next_bus_out;
            o_bus_oe_n <= next_bus_oe_n; // [R9]
            o_clamp_bias <= i_clamp_enable; // [R2]
            o_inhibit <= inhibit_now; // [R6]
            o_output_demux <= cfg_word[`IAP_CFG_FORMAT_BIT]; // [R10]
            o_single_channel <= cfg_word[`IAP_CFG_SINGLE_BIT];
            o_active_channel <= next_channel; // [R7]
            o_mux_reverse <= cfg_word[`IAP_CFG_MUX_ORDER_BIT];
        end
    end

endmodule // iap_port

// ---- include/iap_defs.vh ----
// constants for the image digitizer output and register port
`ifndef IAP_DEFS_VH
`define IAP_DEFS_VH

`define IAP_BUS_W 14
`define IAP_REG_DATA_W 10
`define IAP_REG_ADDR_W 3
`define IAP_REG_COUNT 8
`define IAP_REG_ADDR_LSB 10
`define IAP_REG_ADDR_MSB 12
`define IAP_REG_DATA_MSB 9

`define IAP_CFG_ADDR 3'h0
`define IAP_REG_RESET 10'h000

`define IAP_CFG_SINGLE_BIT 3
`define IAP_CFG_CHSEL_LOW_BIT 4
`define IAP_CFG_CHSEL_HIGH_BIT 5
`define IAP_CFG_MUX_ORDER_BIT 6
`define IAP_CFG_FORMAT_BIT 7

`define IAP_CHAN_RED 2'h0
`define IAP_CHAN_GREEN 2'h1
`define IAP_CHAN_BLUE 2'h2

`define IAP_HIGH_PART_LSB 6
`define IAP_LOW_PART_PIN_LSB 8
`define IAP_LOW_PART_MSB 5

`define IAP_SER_FRAME_BITS 4'hD
`define IAP_SER_COUNT_MAX 4'hF
`define IAP_SER_W 13

`define IAP_PHASE_HIGH 1'b0
`define IAP_PHASE_LOW 1'b1

`endif

// ---- rtl/iap_skid_buf.v ----
// two-entry word buffer between the converter and the output bus
`timescale 1ns/1ps
`include "iap_defs.vh"

module iap_skid_buf #(
    parameter WIDTH = 14,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [WIDTH-1:0] i_in_data,
    input wire i_in_valid,
    output reg o_in_ready,
    output reg [WIDTH-1:0] o_out_data,
    output reg o_out_valid,
    input wire i_out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg [AW:0] next_count;
    reg [AW-1:0] next_rd_ptr;
    wire push;
    wire pop;
    // constants cut to pointer and count width so no compare or sum changes size
    localparam [31:0] LAST_IDX = DEPTH - 1;
    localparam [31:0] FULL_IDX = DEPTH;
    localparam [31:0] STEP_IDX = 1;
    localparam [AW-1:0] LAST_PTR = LAST_IDX[AW-1:0];
    localparam [AW-1:0] PTR_STEP = STEP_IDX[AW-1:0];
    localparam [AW:0] FULL_COUNT = FULL_IDX[AW:0];

    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @*
    begin
        next_count = count;
        next_rd_ptr = rd_ptr;
        if (push && !pop)
        begin
            next_count = count + {{AW{1'b0}}, 1'b1};
        end
        else if (pop && !push)
        begin
            next_count = count - {{AW{1'b0}}, 1'b1};
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == LAST_PTR) ? {AW{1'b0}} : rd_ptr + PTR_STEP;
        end
    end

    // data is presented from a register so the output bus sees a clean word
    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            o_in_ready <= 1'b0;
            o_out_valid <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= i_in_data;
                wr_ptr <= (wr_ptr == LAST_PTR) ? {AW{1'b0}} : wr_ptr + PTR_STEP;
            end
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            o_in_ready <= (next_count != FULL_COUNT);
            o_out_valid <= (next_count != {(AW+1){1'b0}});
            if (next_count == {(AW+1){1'b0}})
            begin
                o_out_data <= o_out_data;
            end
            else if (count == {(AW+1){1'b0}} || (pop && count == {{AW{1'b0}}, 1'b1}))
            begin
                o_out_data <= i_in_data;
            end
            else
            begin
                o_out_data <= mem[next_rd_ptr];
            end
        end
    end

endmodule // iap_skid_buf

// ---- tb/iap_port_props.sv ----
// concurrent checks on the ports of the digitizer host port
`timescale 1ns/1ps
module iap_port_props #(
    parameter BUS_W = 14
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_port_select,
    input wire i_clamp_enable,
    input wire i_out_enable_n,
    input wire i_register_write_strobe,
    input wire i_register_read_strobe,
    input wire [BUS_W-1:0] i_bus_in,
    input wire [BUS_W-1:0] o_bus_oe_n,
    input wire o_clamp_bias,
    input wire o_inhibit,
    input wire o_output_demux,
    input wire [1:0] o_active_channel,
    input wire o_config_written
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    clamp_follow_a: assert property (1 |=> o_clamp_bias == $past(i_clamp_enable))
        else $error("clamp bias wrong");
    inhibit_state_a: assert property ((!i_out_enable_n && i_port_select)
        |=> o_inhibit && (&o_bus_oe_n)) else $error("inhibit wrong");
    bus_release_a: assert property ((i_out_enable_n && !i_register_read_strobe)
        |=> &o_bus_oe_n) else $error("bus not released");
    full_drive_a: assert property ((!i_out_enable_n && !i_port_select && !o_output_demux)
        |=> o_bus_oe_n == 14'h0000) else $error("bus not driven");
    demux_pins_a: assert property ((o_output_demux && !i_port_select)
        |=> &o_bus_oe_n[5:0]) else $error("low pins driven in demux");
    write_pulse_a: assert property (o_config_written |=> !o_config_written)
        else $error("write pulse too long");
    par_write_a: assert property (($rose(i_register_write_strobe) && i_port_select)
        |=> o_config_written) else $error("parallel write lost");
    serial_rise_a: assert property (($rose(i_register_write_strobe) && !i_port_select)
        |=> !o_config_written) else $error("serial rise wrote");
    format_bit_a: assert property (($rose(i_register_write_strobe) && i_port_select
        && i_bus_in[12:10] == 3'h0) |-> ##2 o_output_demux == $past(i_bus_in[7], 2))
        else $error("format bit wrong");
    blue_select_a: assert property (($rose(i_register_write_strobe) && i_port_select
        && i_bus_in[12:10] == 3'h0 && i_bus_in[5:4] == 2'h1) |-> ##2 o_active_channel == 2'h2)
        else $error("blue not selected");
endmodule // iap_port_props

bind iap_port iap_port_props #(.BUS_W(BUS_W)) u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_port_select(i_port_select), .i_clamp_enable(i_clamp_enable),
    .i_out_enable_n(i_out_enable_n), .i_register_write_strobe(i_register_write_strobe),
    .i_register_read_strobe(i_register_read_strobe), .i_bus_in(i_bus_in),
    .o_bus_oe_n(o_bus_oe_n), .o_clamp_bias(o_clamp_bias), .o_inhibit(o_inhibit),
    .o_output_demux(o_output_demux), .o_active_channel(o_active_channel),
    .o_config_written(o_config_written));

// ---- tb/iap_ctl_model.sv ----
// scanner controller model: paces the conversion clock and rebuilds result words
`timescale 1ns/1ps
module iap_ctl_model (
    input wire i_mclk,
    input wire i_step,
    input wire i_demux,
    input wire [13:0] i_pins,
    output reg o_conv_clk = 1'b0,
    output reg [13:0] o_word = 14'h0000,
    output reg o_done = 1'b0
);
    reg [3:0] cnt = 4'h0;
    reg [7:0] hi = 8'h00;
    // four-cycle high phases and low phases of five cycles or more keep each clock level well above the two-cycle minimum
    always @(negedge i_mclk)
    begin
        o_done <= 1'b0;
        if (cnt == 4'h0)
        begin
            if (i_step)
            begin
                o_conv_clk <= 1'b1;
                cnt <= 4'h1;
            end
        end
        else
        begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h4)
            begin
                hi <= i_pins[13:6];
                o_word <= i_pins;
                o_conv_clk <= 1'b0;
            end
            if (cnt == 4'h8)
            begin
                if (i_demux)
                    o_word <= {hi, i_pins[13:8]};
                o_done <= 1'b1;
                cnt <= 4'h0;
            end
        end
    end
endmodule // iap_ctl_model

// ---- tb/iap_port_tb_top.sv ----
// self-checking bench for the digitizer host port
`timescale 1ns/1ps
module iap_port_tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg ps = 1'b0;
    reg clamp = 1'b0;
    reg oe_n = 1'b1;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg sdat = 1'b0;
    reg sclk = 1'b0;
    reg rvalid = 1'b0;
    reg step = 1'b0;
    reg dmx = 1'b0;
    reg [13:0] rdata = 14'h0000;
    reg [13:0] hval = 14'h0000;
    reg [13:0] hmask = 14'h0000;
    reg [13:0] fill = 14'h2AAA;
    integer n_fail = 0;
    integer n_checks = 0;
    integer cyc = 0;
    wire [13:0] bus_out, bus_oe_n, pins, word;
    wire [1:0] chan;
    wire conv, rready, cbias, inh, demux, single, mrev, cfgw, done;
    // released pins read a toggling pattern so stale data cannot pass
    assign pins = (~bus_oe_n & bus_out) | (bus_oe_n & hmask & hval) | (bus_oe_n & ~hmask & fill);
    iap_port dut (.i_mclk(clk), .i_sys_rst(rst), .i_conversion_clock(conv), .i_port_select(ps),
        .i_clamp_enable(clamp), .i_out_enable_n(oe_n), .i_register_write_strobe(wr),
        .i_register_read_strobe(rd), .i_serial_config_data(sdat), .i_serial_shift_clock(sclk),
        .i_bus_in(pins), .o_bus_out(bus_out), .o_bus_oe_n(bus_oe_n), .i_result_data(rdata),
        .i_result_valid(rvalid), .o_result_ready(rready), .o_clamp_bias(cbias), .o_inhibit(inh),
        .o_output_demux(demux), .o_single_channel(single), .o_active_channel(chan),
        .o_mux_reverse(mrev), .o_config_written(cfgw));
    iap_ctl_model ctl (.i_mclk(clk), .i_step(step), .i_demux(dmx), .i_pins(pins),
        .o_conv_clk(conv), .o_word(word), .o_done(done));
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        fill <= ~fill;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail = n_fail + 1;
            conclude;
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string what, input [13:0] exp, input [13:0] got);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chkb(input string what, input exp, input got);
        chk(what, {13'h0000, exp}, {13'h0000, got});
    endtask
    task wr_par(input [2:0] a, input [9:0] d);
        @(negedge clk);
        hmask <= 14'h3FFF;
        hval <= {1'b0, a, d};
        wr <= 1'b1;
        @(negedge clk);
        wr <= 1'b0;
        @(negedge clk);
        hmask <= 14'h0000;
        repeat (2) @(negedge clk);
    endtask
    task push(input [13:0] w);
        integer k;
        k = 0;
        @(negedge clk);
        while (rready !== 1'b1 && k < 20)
        begin
            @(negedge clk);
            k = k + 1;
        end
        rdata <= w;
        rvalid <= 1'b1;
        @(negedge clk);
        rvalid <= 1'b0;
    endtask
    task stepw(input [13:0] w);
        integer k;
        @(negedge clk);
        step <= 1'b1;
        @(negedge clk);
        step <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k = k + 1;
        end
        chk("word", w, word);
    endtask
    task ser(input integer n, input [12:0] f);
        integer i;
        @(negedge clk);
        wr <= 1'b1;
        for (i = 12; i > 12 - n; i = i - 1)
        begin
            @(negedge clk);
            sdat <= f[i];
            @(negedge clk);
            sclk <= 1'b1;
            @(negedge clk);
            sclk <= 1'b0;
        end
        @(negedge clk);
        wr <= 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task t_reset;
        chk("reset drive", 14'h3FFF, bus_oe_n);
        chk("reset channel", 14'h0000, {12'h000, chan});
    endtask
    task t_clamp;
        @(negedge clk);
        clamp <= 1'b1;
        repeat (2) @(negedge clk);
        chkb("clamp on", 1'b1, cbias);
        clamp <= 1'b0;
        repeat (2) @(negedge clk);
        chkb("clamp off", 1'b0, cbias);
    endtask
    task t_config;
        integer i;
        reg [1:0] exp;
        ps <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
            exp = (i == 1) ? 2'h2 : ((i == 2) ? 2'h1 : 2'h0);
            wr_par(3'h0, {4'h1, i[1:0], 4'h8});
            chk("channel", {12'h000, exp}, {12'h000, chan});
            chkb("single", 1'b1, single);
            chkb("reverse", 1'b1, mrev);
            chkb("format", 1'b0, demux);
        end
    endtask
    task t_stream;
        @(negedge clk);
        ps <= 1'b0;
        oe_n <= 1'b0;
        push(14'h2D5A);
        push(14'h1234);
        @(negedge clk);
        chkb("ready when full", 1'b0, rready);
        stepw(14'h2D5A);
        stepw(14'h1234);
        stepw(14'h1234);
        @(negedge clk);
        oe_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk("released", 14'h3FFF, bus_oe_n);
    endtask
    task t_inhibit;
        @(negedge clk);
        ps <= 1'b1;
        oe_n <= 1'b0;
        repeat (2) @(negedge clk);
        chkb("inhibit", 1'b1, inh);
        chk("inhibit drive", 14'h3FFF, bus_oe_n);
        ps <= 1'b0;
        repeat (2) @(negedge clk);
        chkb("inhibit off", 1'b0, inh);
        oe_n <= 1'b1;
    endtask
    task t_serial;
        ser(13, {3'h0, 10'h020});
        chk("serial channel", 14'h0001, {12'h000, chan});
        chkb("serial single", 1'b0, single);
        ser(12, {3'h0, 10'h018});
        chk("short frame", 14'h0001, {12'h000, chan});
    endtask
    task t_read;
        @(negedge clk);
        ps <= 1'b1;
        wr_par(3'h5, 10'h2B7);
        hmask <= 14'h1C00;
        hval <= {1'b0, 3'h5, 10'h000};
        rd <= 1'b1;
        repeat (2) @(negedge clk);
        chk("read data", 14'h02B7, {4'h0, bus_out[9:0]});
        chk("read drive", 14'h3C00, bus_oe_n);
        rd <= 1'b0;
        hmask <= 14'h0000;
    endtask
    task t_demux;
        wr_par(3'h0, 10'h080);
        chkb("format on", 1'b1, demux);
        ps <= 1'b0;
        oe_n <= 1'b0;
        dmx <= 1'b1;
        push(14'h3C96);
        stepw(14'h3C96);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset;
        t_clamp;
        t_config;
        t_stream;
        t_inhibit;
        t_serial;
        t_read;
        t_demux;
        conclude;
    end
endmodule // iap_port_tb_top
